/* File: design/nvm_address_capture.sv */
// Capture of the effective address for data EEPROM erase, write and read.
`timescale 1ns/100ps
module nvm_address_capture
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Retired instruction from the core
	input nvm_addr_pkg::table_instr_t instr,
	// Operation requested by the memory controller
	input wire logic op_valid,
	input nvm_addr_pkg::nvm_op_t op,
	// Captured address
	output nvm_addr_pkg::nvm_addr_t addr,
	output logic [nvm_addr_pkg::EA_WIDTH-1:0] effective_address,
	// Decoded array view
	output logic [nvm_addr_pkg::WORD_INDEX_WIDTH-1:0] word_index,
	output logic [nvm_addr_pkg::WORD_INDEX_WIDTH-1:0] word_first,
	output logic [nvm_addr_pkg::WORD_INDEX_WIDTH-1:0] word_count_m1,
	output logic in_eeprom,
	output logic op_start
);
	import nvm_addr_pkg::*;

	logic [UPPER_WIDTH-1:0] upper_q;
	logic [LOWER_WIDTH-1:0] lower_q;
	logic [EA_WIDTH-1:0] ea_q;
	logic [WORD_INDEX_WIDTH-1:0] index_q;
	logic [WORD_INDEX_WIDTH-1:0] first_q;
	logic [WORD_INDEX_WIDTH-1:0] first_d;
	logic [WORD_INDEX_WIDTH-1:0] count_q;
	logic [WORD_INDEX_WIDTH-1:0] count_d;
	logic in_eeprom_q;
	logic in_window;
	logic start_q;
	logic capture;
	wire logic [EA_WIDTH-1:0] ea_d;
	logic [WORD_INDEX_WIDTH-1:0] idx;

	// The registers are reached only through this port, never through a data bus.
	assign capture = instr.valid && (instr.kind == INSTR_TBLWT);

	// Each incoming address bit either passes through or is tied low where no array cell can exist.
	// Tying the bits here rather than at the outputs keeps the range check and the index on one value.
	for (genvar b = 0; b < EA_WIDTH; b++)
	begin : g_ea_bit
		if (b == LOWER_LSB_POS)
		begin : g_even
			// Only the lower word of each location exists, so an odd address never reaches the array.
			assign ea_d[b] = 1'b0;
		end
		else if (b == LOWER_WIDTH + UPPER_MSB_POS)
		begin : g_user
			assign ea_d[b] = 1'b0;
		end
		else
		begin : g_pass
			assign ea_d[b] = instr.effective_address[b];
		end
	end

	// The upper bound guards a later move of the window; at the top of user space it always holds.
	assign in_window = (ea_d >= EEPROM_BASE) && (ea_d <= EEPROM_LAST);

	// Table reads and other instructions leave both halves untouched.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			upper_q <= UPPER_RESET;
		end
		else if (capture)
		begin
			upper_q <= ea_d[EA_WIDTH-1:LOWER_WIDTH];
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lower_q <= LOWER_RESET;
		end
		else if (capture)
		begin
			lower_q <= ea_d[LOWER_WIDTH-1:0];
		end
	end

	// The combined view is registered so that every output comes from a flip-flop.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ea_q <= {UPPER_RESET, LOWER_RESET};
		end
		else if (capture)
		begin
			ea_q <= ea_d;
		end
	end

	// Word index inside the 256-word array; the byte address steps by two per word.
	assign idx = ea_d[WORD_INDEX_LSB +: WORD_INDEX_WIDTH];

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			index_q <= INDEX_RESET;
		end
		else if (capture)
		begin
			index_q <= idx;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_eeprom_q <= 1'b0;
		end
		else if (capture)
		begin
			in_eeprom_q <= in_window;
		end
	end

	// Erase groups are aligned to their size, so a multi-word erase never wraps the array.
	// An operation in the same cycle as a table write still works on the address captured before it.
	always_comb
	begin
		first_d = first_q;
		count_d = count_q;
		if (op_valid)
		begin
			case (op)
				OP_ERASE4:
				begin
					first_d = index_q & ~ERASE4_COUNT_M1;
					count_d = ERASE4_COUNT_M1;
				end
				OP_ERASE8:
				begin
					first_d = index_q & ~ERASE8_COUNT_M1;
					count_d = ERASE8_COUNT_M1;
				end
				OP_BULK:
				begin
					first_d = BULK_FIRST;
					count_d = BULK_COUNT_M1;
				end
				default:
				begin
					first_d = index_q;
					count_d = SINGLE_COUNT_M1;
				end
			endcase
		end
	end

	// First word and count stand until the next operation replaces them.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			first_q <= INDEX_RESET;
		end
		else
		begin
			first_q <= first_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= INDEX_RESET;
		end
		else
		begin
			count_q <= count_d;
		end
	end

	// The start strobe is held back while the address lies outside the array.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= op_valid && in_eeprom_q;
		end
	end

	// Every output is a plain copy of a register, so no decode sits between a flip-flop and a pin.
	assign addr.nvm_addr_upper = upper_q;
	assign addr.nvm_addr_lower = lower_q;
	assign effective_address = ea_q;
	assign word_index = index_q;
	assign word_first = first_q;
	assign word_count_m1 = count_q;
	assign in_eeprom = in_eeprom_q;
	assign op_start = start_q;

endmodule

/* File: include/nvm_addr_pkg.sv */
// Package with constants and carrier types for the nonvolatile address capture block.
package nvm_addr_pkg;

	localparam int EA_WIDTH = 24;
	localparam int UPPER_WIDTH = 8;
	localparam int LOWER_WIDTH = 16;
	localparam int WORD_INDEX_WIDTH = 8;
	localparam int EEPROM_DEPTH = 256;
	localparam int EEPROM_WORD_BITS = 16;
	localparam int LOWER_LSB_POS = 0;
	localparam int UPPER_MSB_POS = 7;
	localparam int WORD_INDEX_LSB = 1;

	localparam logic [UPPER_WIDTH-1:0] UPPER_RESET = 8'h00;
	localparam logic [LOWER_WIDTH-1:0] LOWER_RESET = 16'h0000;
	localparam logic [WORD_INDEX_WIDTH-1:0] INDEX_RESET = 8'h00;

	// Words covered by each operation, less one, and the first word of a bulk erase.
	localparam logic [WORD_INDEX_WIDTH-1:0] SINGLE_COUNT_M1 = 8'h00;
	localparam logic [WORD_INDEX_WIDTH-1:0] ERASE4_COUNT_M1 = 8'h03;
	localparam logic [WORD_INDEX_WIDTH-1:0] ERASE8_COUNT_M1 = 8'h07;
	localparam logic [WORD_INDEX_WIDTH-1:0] BULK_COUNT_M1 = 8'hFF;
	localparam logic [WORD_INDEX_WIDTH-1:0] BULK_FIRST = 8'h00;

	// Base of the data EEPROM window at the top of user program space.
	localparam logic [EA_WIDTH-1:0] EEPROM_BASE = 24'h7FFE00;
	localparam logic [EA_WIDTH-1:0] EEPROM_LAST = 24'h7FFFFE;

	// Instruction classes that the core reports on its retire strobe.
	typedef enum logic [1:0]
	{
		INSTR_OTHER = 2'h0,
		INSTR_TBLRD = 2'h1,
		INSTR_TBLWT = 2'h3
	} instr_kind_t;

	// Operations that a captured address may serve.
	typedef enum logic [2:0]
	{
		OP_ERASE1 = 3'h0,
		OP_ERASE4 = 3'h1,
		OP_ERASE8 = 3'h3,
		OP_BULK = 3'h2,
		OP_WRITE1 = 3'h6,
		OP_READ1 = 3'h7
	} nvm_op_t;

	// One retired instruction as seen from the core.
	typedef struct packed
	{
		logic valid;
		instr_kind_t kind;
		logic [EA_WIDTH-1:0] effective_address;
	} table_instr_t;

	// Captured address and the view that the memory controller uses.
	typedef struct packed
	{
		logic [UPPER_WIDTH-1:0] nvm_addr_upper;
		logic [LOWER_WIDTH-1:0] nvm_addr_lower;
	} nvm_addr_t;

endpackage

/* File: sim/nvm_core_model.sv */
// Core model that retires table and other instructions.
`timescale 1ns/100ps
module nvm_core_model import nvm_addr_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Retire strobe
	output table_instr_t instr
);
	initial instr = '0;
	// Between retires the address lines carry the inverse, so a stale value is never mistaken for a new one.
	task automatic issue(input instr_kind_t k, input logic [23:0] a);
		@(posedge mclk);
		instr <= {1'b1, k, a};
		@(posedge mclk);
		instr <= {1'b0, k, ~a};
	endtask
endmodule

/* File: sim/nvm_address_capture_asserts.sv */
// Checker for the address capture block.
`timescale 1ns/100ps
module nvm_cap_chk import nvm_addr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input table_instr_t instr,
	input wire logic op_valid,
	input nvm_op_t op,
	input nvm_addr_t addr,
	input wire logic [23:0] effective_address,
	input wire logic [7:0] word_index,
	input wire logic [7:0] word_first,
	input wire logic [7:0] word_count_m1,
	input wire logic in_eeprom,
	input wire logic op_start
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_wr;
		instr.valid && instr.kind == INSTR_TBLWT;
	endsequence
	a_ea_join: assert property (
		effective_address == {addr.nvm_addr_upper, addr.nvm_addr_lower}) else $error("split");
	a_ea_load: assert property (
		s_wr |=> effective_address == ($past(instr.effective_address) & 24'h7FFFFE)) else $error("load");
	a_lsb_zero: assert property (!addr.nvm_addr_lower[0]) else $error("lsb");
	a_msb_zero: assert property (!addr.nvm_addr_upper[7]) else $error("msb");
	a_ea_hold: assert property (
		!(instr.valid && instr.kind == INSTR_TBLWT) |=> $stable(effective_address)) else $error("hold");
	a_word_view: assert property (
		word_index == effective_address[8:1] && in_eeprom == (effective_address >= EEPROM_BASE)) else $error("view");
	a_op_start: assert property (op_valid |=> op_start == $past(in_eeprom)) else $error("start");
	a_erase_eight: assert property (
		op_valid && op == OP_ERASE8 |=> word_first == ($past(word_index) & 8'hF8) && word_count_m1 == 8'h07)
		else $error("erase8");
endmodule
bind nvm_address_capture nvm_cap_chk chk (.*);

/* File: sim/nvm_address_capture_tb.sv */
// Self-checking bench for the address capture block.
`timescale 1ns/100ps
module nvm_address_capture_tb;
	import nvm_addr_pkg::*;
	logic mclk, rst_n, op_valid, t1, iw, in_eeprom, op_start;
	nvm_op_t op;
	table_instr_t instr;
	nvm_addr_t addr;
	logic [23:0] effective_address, r, ea_m;
	logic [7:0] word_index, word_first, word_count_m1, mf, mc;
	logic [73:0] e, got, q[$];
	int bad_count, tests_run;
	nvm_core_model core (.mclk(mclk), .instr(instr));
	nvm_address_capture DUT (.*);
	initial
	begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	function automatic logic [23:0] nx(input logic [23:0] s);
		return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
	endfunction
	task automatic wr(input instr_kind_t k, input logic [23:0] a);
		core.issue(k, a);
		if (k == INSTR_TBLWT)
		begin
			ea_m = a & 24'h7FFFFE;
			iw = ea_m >= EEPROM_BASE;
			q.push_back({1'b0, iw, mf, mc, ea_m, ea_m[8:1], ea_m});
		end
	endtask
	task automatic do_op(input nvm_op_t o);
		@(posedge mclk);
		op_valid <= 1'b1;
		op <= o;
		@(posedge mclk);
		op_valid <= 1'b0;
		mc = o == OP_BULK ? 8'hFF : o == OP_ERASE8 ? 8'h07 : o == OP_ERASE4 ? 8'h03 : 8'h00;
		mf = ea_m[8:1] & ~mc;
		q.push_back({iw, iw, mf, mc, ea_m, ea_m[8:1], ea_m});
	endtask
	always @(posedge mclk) t1 <= rst_n && (op_valid || instr.valid && instr.kind == INSTR_TBLWT);
	always @(negedge mclk)
		if (t1)
		begin
			e = q.pop_front();
			tests_run++;
			got = {op_start, in_eeprom, word_first, word_count_m1, effective_address, word_index, addr};
			if (got !== e)
			begin
				bad_count++;
				$display("BAD %0t %h %h", $time, got, e);
			end
		end
	task automatic test_done;
		$display("%0d checks, %0d bad", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#8000;
		bad_count++;
		test_done;
	end
	initial
	begin
		{rst_n, op_valid, iw, ea_m, mf, mc} = '0;
		op = OP_READ1;
		r = 24'h4B;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		wr(INSTR_TBLWT, 24'hFFFFFF);
		do_op(OP_BULK);
		wr(INSTR_TBLWT, 24'h7FFDFF);
		do_op(OP_ERASE1);
		for (int i = 0; i < 8; i++)
		begin
			r = nx(r);
			wr(INSTR_TBLWT, r[1] ? {r[23], 14'h3FFF, r[8:0]} : r);
			wr(INSTR_TBLRD, nx(r));
			do_op(nvm_op_t'(i[2:0]));
			wr(INSTR_OTHER, ~r);
			$display("test %0d done", i);
		end
		@(negedge mclk);
		test_done;
	end
endmodule
